/* logic/cbuf_cfg.svh */
// constants for the circular buffer address block
// Functional notes
// - one circular buffer in X space, one in Y space; X also covers program
// - wrapping applies alike to data and program space accesses
// - any pointer but 1111 selectable; avoid frame and stack pointers
// - buffers of any length are checked at one bound per step: end going up, start going down
// - four 16-bit boundary registers: X start, X end, Y start, Y end
// - Y space addresses assume word data, bit 0 forced clear
// - no length register; length is end minus start plus one, up to 32K words
// - X select of 1111 disables wrapping in X read and write generators
// - Y select of 1111 disables wrapping in Y generator
// - X select in control bits 3:0, X enable bit 15
// - Y select in control bits 7:4, Y enable bit 14
`ifndef CBUF_CFG_SVH
`define CBUF_CFG_SVH
// ==========================================================
// register byte addresses
`define CBUF_ADDR_CTRL    8'h00
`define CBUF_ADDR_XSTART  8'h04
`define CBUF_ADDR_XEND    8'h08
`define CBUF_ADDR_YSTART  8'h0c
`define CBUF_ADDR_YEND    8'h10
`define CBUF_ADDR_STATUS  8'h14
// ==========================================================
// control fields and reset values
`define CBUF_XSEL_LSB     0
`define CBUF_YSEL_LSB     4
`define CBUF_XEN_BIT      15
`define CBUF_YEN_BIT      14
`define CBUF_SEL_OFF      4'hf
`define CBUF_CTRL_RST     16'h00ff
`define CBUF_BOUND_RST    16'h0000
`endif

/* logic/cbuf_pkg.sv */
// types for the circular buffer address block
package cbuf_pkg;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_RESP = 3'b010,
    BUS_WAIT = 3'b100
  } cbuf_bus_t;
  typedef enum logic [1:0] {
    SPACE_X = 2'h0,
    SPACE_Y = 2'h1,
    SPACE_P = 2'h2
  } cbuf_space_t;
endpackage

/* logic/cbuf_wrap.sv */
// one address generator's modulo wrap stage
`timescale 1ns/1ps
module cbuf_wrap #(
  parameter int AW = 16
) (
  input  wire logic          active,
  input  wire logic          wordOnly,
  input  wire logic [AW-1:0] addrIn,
  input  wire logic [AW-1:0] stepAddr,
  input  wire logic          stepDown,
  input  wire logic [AW-1:0] startBound,
  input  wire logic [AW-1:0] endBound,
  output logic      [AW-1:0] addrOut,
  output logic               wrapped
);
  logic [AW-1:0] lo;
  logic [AW-1:0] hi;
  logic [AW-1:0] nxt;
  // bounds and step, Y forces word alignment
  always_comb begin
    lo = wordOnly ? {startBound[AW-1:1], 1'b0} : startBound;
    hi = wordOnly ? {endBound[AW-1:1], 1'b0} : endBound;
    nxt = wordOnly ? {stepAddr[AW-1:1], 1'b0} : stepAddr;
    addrOut = nxt;
    wrapped = 1'b0;
    // only the bound in the step direction is checked: end going up, start going down
    if (active && !stepDown && addrIn <= hi && nxt > hi) begin
      addrOut = lo;
      wrapped = 1'b1;
    end else if (active && stepDown && addrIn >= lo && nxt < lo) begin
      addrOut = hi;
      wrapped = 1'b1;
    end
  end
endmodule

/* logic/cbuf_top.sv */
// circular buffer address logic with AXI4-Lite registers
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cbuf_cfg.svh"
module cbuf_top #(
  parameter int AW = 16
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  agValid,
  input  wire cbuf_pkg::cbuf_space_t agSpace,
  input  wire logic                  agWrite,
  input  wire logic [3:0]            agPtr,
  input  wire logic [AW-1:0]         agAddr,
  input  wire logic [AW-1:0]         agStep,
  input  wire logic                  agDown,
  output logic [AW-1:0]             agResult_q,
  output logic                       agWrapped_q,
  output logic                       agValidOut_q
);
  import cbuf_pkg::*;

  // ==========================================================
  // registers
  logic [15:0] ctrl_q;
  logic [15:0] xStart_q;
  logic [15:0] xEnd_q;
  logic [15:0] yStart_q;
  logic [15:0] yEnd_q;
  logic [1:0]  wrapSeen_q;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        awHave_q;
  logic        wHave_q;
  cbuf_bus_t   wrState_q;

  // ==========================================================
  // control decode
  logic [3:0] xSel;
  logic [3:0] ySel;
  logic       xActive;
  logic       yActive;
  logic       useY;
  logic       active;
  logic [AW-1:0] res;
  logic          wr;
  logic [15:0]   wMerged;
  logic          wrGo;

  assign xSel = ctrl_q[`CBUF_XSEL_LSB +: 4];
  assign ySel = ctrl_q[`CBUF_YSEL_LSB +: 4];
  // select 1111 turns wrapping off for both X generators or Y
  assign xActive = ctrl_q[`CBUF_XEN_BIT] && xSel != `CBUF_SEL_OFF;
  assign yActive = ctrl_q[`CBUF_YEN_BIT] && ySel != `CBUF_SEL_OFF;
  // program space shares the X buffer; read and write alike
  assign useY = agSpace == SPACE_Y;
  // any pointer but 1111 may match the select, stack ones included
  assign active = useY ? (yActive && agPtr == ySel)
                       : (xActive && agPtr == xSel);

  // length only implied by the two bounds
  cbuf_wrap #(
    .AW (AW)
  ) u_wrap (
    .active     (active),
    .wordOnly   (useY),
    .addrIn     (agAddr),
    .stepAddr   (agStep),
    .stepDown   (agDown),
    .startBound (useY ? yStart_q[AW-1:0] : xStart_q[AW-1:0]),
    .endBound   (useY ? yEnd_q[AW-1:0] : xEnd_q[AW-1:0]),
    .addrOut    (res),
    .wrapped    (wr)
  );

  // registered generator result
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      agResult_q   <= '0;
      agWrapped_q  <= 1'b0;
      agValidOut_q <= 1'b0;
    end else begin
      agValidOut_q <= agValid;
      if (agValid) begin
        agResult_q  <= res;
        agWrapped_q <= wr;
      end
    end
  end

  // ==========================================================
  // AXI write channel
  assign wrGo = awHave_q && wHave_q && wrState_q == BUS_IDLE;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awHave_q      <= 1'b0;
      wHave_q       <= 1'b0;
      awAddr_q      <= 8'h00;
      wData_q       <= 32'h0;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      wrState_q     <= BUS_IDLE;
    end else begin
      s_axi_awready <= !awHave_q && !s_axi_awready &&
                       wrState_q == BUS_IDLE;
      s_axi_wready  <= !wHave_q && !s_axi_wready &&
                       wrState_q == BUS_IDLE;
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      case (wrState_q)
        BUS_IDLE: begin
          if (wrGo) begin
            awHave_q     <= 1'b0;
            wHave_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_q > `CBUF_ADDR_STATUS ||
                             awAddr_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
            wrState_q    <= BUS_RESP;
          end
        end
        BUS_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wrState_q    <= BUS_IDLE;
          end
        end
        default: wrState_q <= BUS_IDLE;
      endcase
    end
  end

  // byte-lane merge over the addressed register
  always_comb begin
    wMerged = ctrl_q;
    if (awAddr_q == `CBUF_ADDR_XSTART) begin
      wMerged = xStart_q;
    end else if (awAddr_q == `CBUF_ADDR_XEND) begin
      wMerged = xEnd_q;
    end else if (awAddr_q == `CBUF_ADDR_YSTART) begin
      wMerged = yStart_q;
    end else if (awAddr_q == `CBUF_ADDR_YEND) begin
      wMerged = yEnd_q;
    end
    if (wStrb_q[0]) begin
      wMerged[7:0] = wData_q[7:0];
    end
    if (wStrb_q[1]) begin
      wMerged[15:8] = wData_q[15:8];
    end
  end

  // control and four 16-bit bounds
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q   <= `CBUF_CTRL_RST;
      xStart_q <= `CBUF_BOUND_RST;
      xEnd_q   <= `CBUF_BOUND_RST;
      yStart_q <= `CBUF_BOUND_RST;
      yEnd_q   <= `CBUF_BOUND_RST;
    end else if (wrGo) begin
      if (awAddr_q == `CBUF_ADDR_CTRL) begin
        ctrl_q <= wMerged;
      end else if (awAddr_q == `CBUF_ADDR_XSTART) begin
        xStart_q <= wMerged;
      end else if (awAddr_q == `CBUF_ADDR_XEND) begin
        xEnd_q <= wMerged;
      end else if (awAddr_q == `CBUF_ADDR_YSTART) begin
        yStart_q <= wMerged;
      end else if (awAddr_q == `CBUF_ADDR_YEND) begin
        yEnd_q <= wMerged;
      end
    end
  end

  // sticky wrap seen flags, set beats write-one clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrapSeen_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (agValid && wr && (useY == (i == 1))) begin
          wrapSeen_q[i] <= 1'b1;
        end else if (wrGo && awAddr_q == `CBUF_ADDR_STATUS &&
                     wStrb_q[0] && wData_q[i]) begin
          wrapSeen_q[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // AXI read channel
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        if (s_axi_araddr == `CBUF_ADDR_CTRL) begin
          s_axi_rdata <= {16'h0, ctrl_q};
        end else if (s_axi_araddr == `CBUF_ADDR_XSTART) begin
          s_axi_rdata <= {16'h0, xStart_q};
        end else if (s_axi_araddr == `CBUF_ADDR_XEND) begin
          s_axi_rdata <= {16'h0, xEnd_q};
        end else if (s_axi_araddr == `CBUF_ADDR_YSTART) begin
          s_axi_rdata <= {16'h0, yStart_q};
        end else if (s_axi_araddr == `CBUF_ADDR_YEND) begin
          s_axi_rdata <= {16'h0, yEnd_q};
        end else if (s_axi_araddr == `CBUF_ADDR_STATUS) begin
          s_axi_rdata <= {28'h0, yActive, xActive, wrapSeen_q};
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2; // unmapped: slave error
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* tb/cbuf_top_sva.sv */
// checker for the circular buffer address block
`timescale 1ns/1ps
module cbuf_chk #(
  parameter int AW = 16
) (
  input wire logic          mclk,
  input wire logic          rst,
  input wire logic          agValid,
  input wire cbuf_pkg::cbuf_space_t agSpace,
  input wire logic [3:0]    agPtr,
  input wire logic [AW-1:0] agAddr,
  input wire logic [AW-1:0] agStep,
  input wire logic [AW-1:0] agResult_q,
  input wire logic          agWrapped_q,
  input wire logic          agValidOut_q,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic [31:0]   s_axi_rdata
);
  import cbuf_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================================
  // generator answer
  ans_on_a: assert property (agValid |=> agValidOut_q)
    else $error("generator answer missing");
  ans_off_a: assert property (!agValid |=> !agValidOut_q)
    else $error("generator answer without request");
  res_hold_a: assert property (!agValid |=> $stable(agResult_q))
    else $error("pointer result moved while idle");
  pass_thru_a: assert property (agValid && agSpace != SPACE_Y
    |=> agWrapped_q || agResult_q == $past(agStep))
    else $error("unwrapped result differs from step");
  y_word_a: assert property (agValid && agSpace == SPACE_Y
    |=> !agResult_q[0]) else $error("Y result bit 0 set");
  sel_off_a: assert property (agValid && agPtr == 4'hf
    |=> !agWrapped_q) else $error("wrap on disabled select");
  no_move_a: assert property (agValid && agStep == agAddr
    |=> !agWrapped_q) else $error("wrap without a step");
  // ==========================================================
  // register bus answers stand
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
endmodule
bind cbuf_top cbuf_chk #(.AW(AW)) u_cbuf_chk (
  .mclk         (mclk),
  .rst          (rst),
  .agValid      (agValid),
  .agSpace      (agSpace),
  .agPtr        (agPtr),
  .agAddr       (agAddr),
  .agStep       (agStep),
  .agResult_q   (agResult_q),
  .agWrapped_q  (agWrapped_q),
  .agValidOut_q (agValidOut_q),
  .s_axi_bvalid (s_axi_bvalid),
  .s_axi_bready (s_axi_bready),
  .s_axi_rvalid (s_axi_rvalid),
  .s_axi_rready (s_axi_rready),
  .s_axi_rdata  (s_axi_rdata)
);

/* tb/cbuf_core_model.sv */
// core side model: pointer file driving the address generator
`timescale 1ns/1ps
module cbuf_core_model (
  input  wire logic        mclk,
  output logic             agValid,
  output cbuf_pkg::cbuf_space_t agSpace,
  output logic             agWrite,
  output logic [3:0]       agPtr,
  output logic [15:0]      agAddr,
  output logic [15:0]      agStep,
  output logic             agDown,
  input  wire logic [15:0] agResult_q,
  input  wire logic        agWrapped_q,
  input  wire logic        agValidOut_q
);
  import cbuf_pkg::*;
  logic [15:0] wreg [16];
  // idle request lines at time zero
  initial begin
    {agValid, agWrite, agPtr, agAddr, agStep, agDown} = '0;
    agSpace = SPACE_X;
  end
  // one pointer update, result written back to the pointer file
  task automatic step(input cbuf_space_t sp, input logic [3:0] p,
    input logic [15:0] a, input logic [15:0] d, input logic dn,
    input int gap, output logic [15:0] res, output logic wp);
    repeat (gap) @(posedge mclk);
    agValid <= 1'b1;
    agSpace <= sp;
    agPtr   <= p;
    agAddr  <= a;
    agStep  <= dn ? a - d : a + d;
    agDown  <= dn;
    agWrite <= ~agWrite;
    @(posedge mclk);
    agValid <= 1'b0;
    for (int n = 0; n < 8; n++) begin
      @(posedge mclk);
      if (agValidOut_q) break;
    end
    // no answer in time: unknown result trips the bench compare
    res = agValidOut_q ? agResult_q : 16'hxxxx;
    wp = agValidOut_q ? agWrapped_q : 1'bx;
    wreg[p] = res;
  endtask
endmodule

/* tb/cbuf_top_tb_top.sv */
// self-checking bench for the circular buffer address block
`timescale 1ns/1ps
`include "cbuf_cfg.svh"
module cbuf_top_tb_top;
  import cbuf_pkg::*;
  logic        mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, agValid, agWrite;
  logic        agDown, agWrapped_q, agValidOut_q, wp;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb, agPtr;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
  logic [15:0] agAddr, agStep, agResult_q, res;
  cbuf_space_t agSpace;
  int          err_total, n_compared, respLag;
  cbuf_top u_cbuf_top (
    .mclk          (mclk),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .agValid       (agValid),
    .agSpace       (agSpace),
    .agWrite       (agWrite),
    .agPtr         (agPtr),
    .agAddr        (agAddr),
    .agStep        (agStep),
    .agDown        (agDown),
    .agResult_q    (agResult_q),
    .agWrapped_q   (agWrapped_q),
    .agValidOut_q  (agValidOut_q)
  );
  cbuf_core_model u_cbuf_core_model (
    .mclk         (mclk),
    .agValid      (agValid),
    .agSpace      (agSpace),
    .agWrite      (agWrite),
    .agPtr        (agPtr),
    .agAddr       (agAddr),
    .agStep       (agStep),
    .agDown       (agDown),
    .agResult_q   (agResult_q),
    .agWrapped_q  (agWrapped_q),
    .agValidOut_q (agValidOut_q)
  );
  // clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #20us;
    err_total++;
    give_verdict;
  end
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // respLag edges pass before bready or rready rises, so answers must stand
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (respLag == 0);
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
      if (n == respLag) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (respLag == 0);
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
      if (n == respLag) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic stp(input cbuf_space_t sp, input logic [3:0] p,
    input logic [15:0] a, input logic [15:0] d, input logic dn,
    input logic [15:0] e, input logic ew);
    u_cbuf_core_model.step(sp, p, a, d, dn, 0, res, wp);
    chk("pointer", {16'h0000, e}, {16'h0000, res});
    chk("wrapped", {31'h0, ew}, {31'h0, wp});
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================================
  // test sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    rst = 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(`CBUF_ADDR_CTRL);
    chk("control", 32'h000000ff, rv);
    rd(`CBUF_ADDR_XSTART);
    chk("x start", 32'h00000000, rv);
    rd(8'h20);
    chk("unmapped", 32'h00000002, {30'h0, rr});
    wr(8'h20, 32'h00001234);
    chk("bad write", 32'h00000002, {30'h0, br});
    wr(8'h06, 32'h00001234);
    chk("odd write", 32'h00000002, {30'h0, br});
    $display("reset test done");
    wr(`CBUF_ADDR_XSTART, 32'h00001100);
    respLag = 4;
    wr(`CBUF_ADDR_XEND, 32'h00001163);
    wr(`CBUF_ADDR_CTRL, 32'h00008001);
    chk("write resp", 32'h00000000, {30'h0, br});
    rd(`CBUF_ADDR_XEND);
    respLag = 0;
    chk("x end", 32'h00001163, rv);
    stp(SPACE_X, 4'h1, 16'h1162, 16'h2, 1'b0, 16'h1100, 1'b1);
    stp(SPACE_X, 4'h1, 16'h1100, 16'h2, 1'b1, 16'h1163, 1'b1);
    stp(SPACE_P, 4'h1, 16'h1162, 16'h2, 1'b0, 16'h1100, 1'b1);
    stp(SPACE_X, 4'h1, 16'h1110, 16'h2, 1'b0, 16'h1112, 1'b0);
    stp(SPACE_X, 4'h2, 16'h1162, 16'h2, 1'b0, 16'h1164, 1'b0);
    stp(SPACE_Y, 4'h1, 16'h1162, 16'h2, 1'b0, 16'h1164, 1'b0);
    rd(`CBUF_ADDR_STATUS);
    chk("status", 32'h00000005, rv);
    wr(`CBUF_ADDR_CTRL, 32'h0000800f);
    stp(SPACE_X, 4'hf, 16'h1162, 16'h2, 1'b0, 16'h1164, 1'b0);
    wr(`CBUF_ADDR_CTRL, 32'h00000001);
    stp(SPACE_X, 4'h1, 16'h1162, 16'h2, 1'b0, 16'h1164, 1'b0);
    $display("x buffer test done");
    wr(`CBUF_ADDR_YSTART, 32'h00002000);
    wr(`CBUF_ADDR_YEND, 32'h0000201f);
    wr(`CBUF_ADDR_CTRL, 32'h00004020);
    rd(`CBUF_ADDR_STATUS);
    chk("status y on", 32'h00000009, rv);
    stp(SPACE_Y, 4'h2, 16'h2010, 16'h0, 1'b0, 16'h2010, 1'b0);
    stp(SPACE_Y, 4'h2, 16'h201e, 16'h2, 1'b0, 16'h2000, 1'b1);
    stp(SPACE_Y, 4'h2, 16'h2000, 16'h2, 1'b1, 16'h201e, 1'b1);
    wr(`CBUF_ADDR_CTRL, 32'h000040f0);
    stp(SPACE_Y, 4'hf, 16'h201e, 16'h2, 1'b0, 16'h2020, 1'b0);
    rd(`CBUF_ADDR_STATUS);
    chk("status both", 32'h00000003, rv);
    wr(`CBUF_ADDR_STATUS, 32'h00000001);
    rd(`CBUF_ADDR_STATUS);
    chk("status clear", 32'h00000002, rv);
    s_axi_wstrb <= 4'h2;
    wr(`CBUF_ADDR_YSTART, 32'h00003355);
    s_axi_wstrb <= 4'hf;
    rd(`CBUF_ADDR_YSTART);
    chk("y start lane", 32'h00003300, rv);
    $display("y buffer test done");
    give_verdict;
  end
endmodule
